/* cpw_defines.svh */
`ifndef CPW_DEFINES_SVH
`define CPW_DEFINES_SVH
// register byte offsets, decoded from haddr[7:2]
`define CPW_OFS_CTRL 8'h00
`define CPW_OFS_DLOW 8'h04
`define CPW_OFS_DHIGH 8'h08
`define CPW_OFS_PERIOD 8'h0c
`define CPW_OFS_PTCTL 8'h10
`define CPW_OFS_STATUS 8'h14
`define CPW_OFS_TIMER 8'h18
`define CPW_OFS_ADC 8'h1c
// channel_control fields
`define CPW_CTRL_MODE_LSB 0
`define CPW_CTRL_MODE_MSB 3
`define CPW_CTRL_DCB_LSB 4
`define CPW_CTRL_DCB_MSB 5
// channel_mode_field codes
`define CPW_MODE_OFF 4'h0
`define CPW_MODE_TOGGLE 4'h2
`define CPW_MODE_SET 4'h8
`define CPW_MODE_CLEAR 4'h9
`define CPW_MODE_SWINT 4'ha
`define CPW_MODE_SPECIAL 4'hb
`define CPW_MODE_PWM_TOP 2'h3
// status bits, write one to clear
`define CPW_ST_MATCH 0
`define CPW_ST_OVF 1
// period_timer_control and converter control fields
`define CPW_PT_PS_LSB 0
`define CPW_PT_PS_MSB 1
`define CPW_PT_ON 2
`define CPW_ADC_ON 0
`define CPW_ADC_GO 1
// prescaler wrap counts: 4 phases times prescale 1, 4, 16
`define CPW_PS1_LIM 6'h03
`define CPW_PS4_LIM 6'h0f
`define CPW_PS16_LIM 6'h3f
`define CPW_RESET_BYTE 8'h00
`define CPW_HSIZE_WORD 3'h2
`endif

/* cpw_pkg.sv */
package cpw_pkg;
  typedef struct packed {
    logic [15:0] cnt;
    logic match_d;
  } cpw_cmp_state_t;

  typedef struct packed {
    logic [7:0] tmr;
    logic [5:0] pre;
    logic [1:0] lat;
    logic level;
  } cpw_pwm_state_t;

  typedef struct packed {
    logic [5:0] ctrl;
    logic [7:0] dlow;
    logic [7:0] dhigh;
    logic [7:0] period;
    logic [2:0] ptctl;
    logic match_flag;
    logic ovf_flag;
    logic adc_on;
    logic adc_go;
    logic cmp_latch;
    logic trig;
    logic a_valid;
    logic a_write;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic pin_out;
    logic pin_oe_n;
  } cpw_top_state_t;
endpackage : cpw_pkg

/* cpw_cmp.sv */
`timescale 1ns/1ps
`include "cpw_defines.svh"
module cpw_cmp (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic timer_tick,
  input wire logic timer_load,
  input wire logic [15:0] timer_load_val,
  input wire logic [15:0] compare_val,
  input wire logic special_mode,
  output logic [15:0] count,
  output logic match_evt,
  output logic overflow_evt
);
  cpw_pkg::cpw_cmp_state_t state_r;
  cpw_pkg::cpw_cmp_state_t state_nxt;
  logic match_now;
  logic trig_clear;

  assign match_now = (state_r.cnt == compare_val);
  assign match_evt = match_now & ~state_r.match_d;
  // reset only if the match still stands at the timer edge
  assign trig_clear = special_mode & match_now;
  assign overflow_evt = timer_tick & ~timer_load & ~trig_clear & (state_r.cnt == 16'hffff);
  assign count = state_r.cnt;

  always_comb
  begin
    state_nxt = state_r;
    state_nxt.match_d = match_now;
    if (timer_load)
    begin
      state_nxt.cnt = timer_load_val;
    end
    else if (timer_tick)
    begin
      if (trig_clear)
      begin
        state_nxt.cnt = 16'h0000;
      end
      else
      begin
        state_nxt.cnt = state_r.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= '0;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
    end
  end
endmodule : cpw_cmp

/* cpw_pwm.sv */
`timescale 1ns/1ps
`include "cpw_defines.svh"
module cpw_pwm (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic enable,
  input wire logic [1:0] prescale,
  input wire logic [7:0] period,
  input wire logic [9:0] duty_next,
  input wire logic [7:0] duty_high,
  input wire logic pwm_active,
  output logic rollover,
  output logic level,
  output logic [7:0] timer_value
);
  cpw_pkg::cpw_pwm_state_t state_r;
  cpw_pkg::cpw_pwm_state_t state_nxt;
  logic wrap;
  logic [9:0] base;
  logic duty_hit;

  function automatic logic [5:0] cpw_limit(input logic [1:0] ps);
    case (ps)
      2'h0: cpw_limit = `CPW_PS1_LIM;
      2'h1: cpw_limit = `CPW_PS4_LIM;
      default: cpw_limit = `CPW_PS16_LIM;
    endcase
  endfunction : cpw_limit

  // two low time-base bits: clock phase at 1:1, else top prescaler bits
  function automatic logic [1:0] cpw_phase(input logic [1:0] ps, input logic [5:0] pre);
    case (ps)
      2'h0: cpw_phase = pre[1:0];
      2'h1: cpw_phase = pre[3:2];
      default: cpw_phase = pre[5:4];
    endcase
  endfunction : cpw_phase

  assign wrap = enable & (state_r.pre == cpw_limit(prescale));
  assign rollover = wrap & (state_r.tmr == period);
  assign base = {state_r.tmr, cpw_phase(prescale, state_r.pre)};
  assign duty_hit = ({duty_high, state_r.lat} == base);
  // drop in the very cycle the time base reaches the duty value, so high lasts duty time-base steps
  assign level = state_r.level & ~duty_hit;
  assign timer_value = state_r.tmr;

  always_comb
  begin
    state_nxt = state_r;
    if (enable)
    begin
      state_nxt.pre = wrap ? 6'h00 : state_r.pre + 6'h01;
      if (wrap)
      begin
        state_nxt.tmr = rollover ? 8'h00 : state_r.tmr + 8'h01;
      end
    end
    if (!pwm_active)
    begin
      state_nxt.level = 1'b0;
    end
    else if (rollover)
    begin
      state_nxt.lat = duty_next[1:0];
      state_nxt.level = (duty_next != 10'h000);
    end
    else if (duty_hit)
    begin
      state_nxt.level = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= '0;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
    end
  end
endmodule : cpw_pwm

/* cpw_top.sv */
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "cpw_defines.svh"
module cpw_top #(
  parameter bit SECOND_CHANNEL = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic timer_tick,
  input wire logic adc_done,
  input wire logic port_data_latch,
  input wire logic pin_direction_bit,
  output logic channel_output_pin,
  output logic channel_output_pin_oe_n,
  output logic special_event_trigger,
  output logic conversion_start,
  output logic channel_match_flag
);
  cpw_pkg::cpw_top_state_t state_r;
  cpw_pkg::cpw_top_state_t state_nxt;
  logic [3:0] mode;
  logic pwm_mode;
  logic wr_now;
  logic timer_load;
  logic [15:0] timer_count;
  logic match_evt;
  logic overflow_evt;
  logic rollover;
  logic pwm_level;
  logic [7:0] period_timer_value;

  function automatic logic cpw_is_pwm(input logic [3:0] m);
    cpw_is_pwm = (m[3:2] == `CPW_MODE_PWM_TOP);
  endfunction : cpw_is_pwm

  // modes that raise the match flag
  function automatic logic cpw_is_cmp(input logic [3:0] m);
    cpw_is_cmp = (m == `CPW_MODE_TOGGLE) || (m == `CPW_MODE_SET) ||
                 (m == `CPW_MODE_CLEAR) || (m == `CPW_MODE_SWINT) ||
                 (m == `CPW_MODE_SPECIAL);
  endfunction : cpw_is_cmp

  // modes in which the channel, not the port latch, sets the pin level
  function automatic logic cpw_owns_pin(input logic [3:0] m);
    cpw_owns_pin = (m == `CPW_MODE_TOGGLE) || (m == `CPW_MODE_SET) ||
                   (m == `CPW_MODE_CLEAR) || cpw_is_pwm(m);
  endfunction : cpw_owns_pin

  function automatic logic [31:0] cpw_read(
    input cpw_pkg::cpw_top_state_t st,
    input logic [7:0] a,
    input logic [15:0] t1,
    input logic [7:0] t2
  );
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      `CPW_OFS_CTRL: d[5:0] = st.ctrl;
      `CPW_OFS_DLOW: d[7:0] = st.dlow;
      `CPW_OFS_DHIGH: d[7:0] = st.dhigh;
      `CPW_OFS_PERIOD: d[7:0] = st.period;
      `CPW_OFS_PTCTL:
      begin
        d[2:0] = st.ptctl;
        d[15:8] = t2;
      end
      `CPW_OFS_STATUS:
      begin
        d[`CPW_ST_MATCH] = st.match_flag;
        d[`CPW_ST_OVF] = st.ovf_flag;
      end
      `CPW_OFS_TIMER: d[15:0] = t1;
      `CPW_OFS_ADC:
      begin
        d[`CPW_ADC_ON] = st.adc_on;
        d[`CPW_ADC_GO] = st.adc_go;
      end
      default: d = 32'h0000_0000;
    endcase
    cpw_read = d;
  endfunction : cpw_read

  assign mode = state_r.ctrl[`CPW_CTRL_MODE_MSB:`CPW_CTRL_MODE_LSB];
  assign pwm_mode = cpw_is_pwm(mode);
  assign wr_now = state_r.a_valid & state_r.a_write;
  assign timer_load = wr_now & (state_r.a_addr == `CPW_OFS_TIMER);

  cpw_cmp u_cmp (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .timer_tick(timer_tick),
    .timer_load(timer_load),
    .timer_load_val(hwdata[15:0]),
    .compare_val({state_r.dhigh, state_r.dlow}),
    .special_mode(mode == `CPW_MODE_SPECIAL),
    .count(timer_count),
    .match_evt(match_evt),
    .overflow_evt(overflow_evt)
  );

  cpw_pwm u_pwm (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .enable(state_r.ptctl[`CPW_PT_ON]),
    .prescale(state_r.ptctl[`CPW_PT_PS_MSB:`CPW_PT_PS_LSB]),
    .period(state_r.period),
    .duty_next({state_r.dlow, state_r.ctrl[`CPW_CTRL_DCB_MSB:`CPW_CTRL_DCB_LSB]}),
    .duty_high(state_r.dhigh),
    .pwm_active(pwm_mode),
    .rollover(rollover),
    .level(pwm_level),
    .timer_value(period_timer_value)
  );

  always_comb
  begin
    state_nxt = state_r;
    state_nxt.trig = 1'b0;
    state_nxt.hreadyout = 1'b1;
    state_nxt.hresp = 1'b0;

    // data phase of a write: the word is on hwdata now
    if (wr_now)
    begin
      case (state_r.a_addr)
        `CPW_OFS_CTRL:
        begin
          state_nxt.ctrl = hwdata[5:0];
          if (hwdata[`CPW_CTRL_MODE_MSB:`CPW_CTRL_MODE_LSB] == `CPW_MODE_OFF)
          begin
            state_nxt.cmp_latch = 1'b0;
          end
        end
        `CPW_OFS_DLOW: state_nxt.dlow = hwdata[7:0];
        `CPW_OFS_DHIGH:
        begin
          if (!pwm_mode)
          begin
            state_nxt.dhigh = hwdata[7:0];
          end
        end
        `CPW_OFS_PERIOD: state_nxt.period = hwdata[7:0];
        `CPW_OFS_PTCTL: state_nxt.ptctl = hwdata[2:0];
        `CPW_OFS_STATUS:
        begin
          if (hwdata[`CPW_ST_MATCH])
          begin
            state_nxt.match_flag = 1'b0;
          end
          if (hwdata[`CPW_ST_OVF])
          begin
            state_nxt.ovf_flag = 1'b0;
          end
        end
        `CPW_OFS_ADC:
        begin
          state_nxt.adc_on = hwdata[`CPW_ADC_ON];
          state_nxt.adc_go = hwdata[`CPW_ADC_GO];
        end
        default:
        begin
          state_nxt.hresp = 1'b0;
        end
      endcase
    end

    if (adc_done)
    begin
      state_nxt.adc_go = 1'b0;
    end

    // hardware events come after the software clears so that a set wins
    if (match_evt && cpw_is_cmp(mode))
    begin
      state_nxt.match_flag = 1'b1;
      case (mode)
        `CPW_MODE_TOGGLE: state_nxt.cmp_latch = ~state_r.cmp_latch;
        `CPW_MODE_SET: state_nxt.cmp_latch = 1'b1;
        `CPW_MODE_CLEAR: state_nxt.cmp_latch = 1'b0;
        `CPW_MODE_SPECIAL:
        begin
          state_nxt.trig = 1'b1;
          if (SECOND_CHANNEL && state_r.adc_on)
          begin
            state_nxt.adc_go = 1'b1;
          end
        end
        default:
        begin
          state_nxt.trig = 1'b0;
        end
      endcase
    end

    if (overflow_evt)
    begin
      state_nxt.ovf_flag = 1'b1;
    end

    if (rollover && pwm_mode)
    begin
      state_nxt.dhigh = state_r.dlow;
    end

    // pin mux: channel level while it owns the pin, port latch otherwise
    if (pwm_mode)
    begin
      state_nxt.pin_out = pwm_level;
    end
    else if (cpw_owns_pin(mode))
    begin
      state_nxt.pin_out = state_r.cmp_latch;
    end
    else
    begin
      state_nxt.pin_out = port_data_latch;
    end
    state_nxt.pin_oe_n = pin_direction_bit;

    // address phase: capture it and prepare read data from the next state
    if (hsel && hready && htrans[1])
    begin
      state_nxt.a_valid = (hsize == `CPW_HSIZE_WORD);
      state_nxt.a_write = hwrite;
      state_nxt.a_addr = {haddr[7:2], 2'h0};
      if (!hwrite)
      begin
        state_nxt.hrdata = cpw_read(state_nxt, {haddr[7:2], 2'h0}, timer_count,
                                    period_timer_value);
      end
    end
    else if (hready)
    begin
      state_nxt.a_valid = 1'b0;
    end
  end

  // clock enable low freezes everything, including the compare path
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= '0;
      state_r.hreadyout <= 1'b1;
      state_r.pin_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
    end
  end

  assign hreadyout = state_r.hreadyout;
  assign hrdata = state_r.hrdata;
  assign hresp = state_r.hresp;
  assign channel_output_pin = state_r.pin_out;
  assign channel_output_pin_oe_n = state_r.pin_oe_n;
  assign special_event_trigger = state_r.trig;
  assign conversion_start = state_r.adc_go;
  assign channel_match_flag = state_r.match_flag;
endmodule : cpw_top

/* cpw_top_props.sv */
`timescale 1ns/1ps
module cpw_top_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic pin_direction_bit,
  input wire logic channel_output_pin_oe_n,
  input wire logic special_event_trigger,
  input wire logic conversion_start,
  input wire logic channel_match_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_ready;
    hreadyout;
  endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  property p_resp;
    !hresp;
  endproperty
  a_resp: assert property (p_resp) else $error("hresp not okay");
  property p_upper;
    hrdata[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("read data upper half set");
  property p_rd_hold;
    !(ce && hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  property p_trig_pulse;
    special_event_trigger |=> !special_event_trigger;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger longer than a cycle");
  property p_trig_flag;
    special_event_trigger |-> channel_match_flag;
  endproperty
  a_trig_flag: assert property (p_trig_flag) else $error("trigger without match flag");
  property p_flag_clr;
    $fell(channel_match_flag) |-> $past(hsel && hready && htrans[1] && hwrite, 2);
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("match flag lost without write");
  property p_oe;
    ce |=> channel_output_pin_oe_n == $past(pin_direction_bit);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable does not follow direction");
  c_trig: cover property (special_event_trigger);
  c_flag: cover property ($fell(channel_match_flag));
  c_conv: cover property ($rose(conversion_start));
endmodule : cpw_top_props

bind cpw_top cpw_top_props cpw_top_props_i (.*);

/* cpw_far.sv */
`timescale 1ns/1ps
module cpw_far #(
  parameter int TDIV = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick_en,
  input wire logic conversion_start,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  output logic timer_tick,
  output logic adc_done,
  output logic pin_wire
);
  int div_r;
  int conv_r;
  // pull-up holds the line high once nobody drives it
  assign pin_wire = pin_oe_n ? 1'b1 : pin_out;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_r <= 0;
      conv_r <= 0;
      timer_tick <= 1'b0;
      adc_done <= 1'b0;
    end
    else
    begin
      div_r <= (div_r == TDIV - 1) ? 0 : div_r + 1;
      // synchronous timer clock, divided from the system clock
      timer_tick <= tick_en && div_r == TDIV - 1;
      conv_r <= conversion_start ? conv_r + 1 : 0;
      adc_done <= conversion_start && conv_r == 20;
    end
  end
endmodule : cpw_far

/* cpw_top_test.sv */
`timescale 1ns/1ps
module cpw_top_test;
  localparam int TD = 8;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic timer_tick;
  logic adc_done;
  logic port_data_latch = 1'b0;
  logic pin_direction_bit = 1'b1;
  logic tick_en = 1'b1;
  logic ce = 1'b1;
  logic channel_output_pin;
  logic channel_output_pin_oe_n;
  logic special_event_trigger;
  logic conversion_start;
  logic channel_match_flag;
  logic pin_wire;
  logic [31:0] rd;
  logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
  logic [3:0] mode [3] = '{4'h8, 4'h9, 4'h2};
  logic lvl [3] = '{1'b1, 1'b0, 1'b1};
  int errors = 0;
  int check_count = 0;
  int n;
  int hi;
  int lo;
  cpw_top cpw_top_i (.*, .hready(hreadyout));
  cpw_far #(.TDIV(TD)) cpw_far_i (.clk(clk), .sys_rst(sys_rst), .tick_en(tick_en),
    .conversion_start(conversion_start), .pin_out(channel_output_pin),
    .pin_oe_n(channel_output_pin_oe_n), .timer_tick(timer_tick), .adc_done(adc_done),
    .pin_wire(pin_wire));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic hang();
    errors++;
    $display("[FAIL] %0t wait ran out", $time);
    give_verdict();
  endtask : hang
  task automatic rdy();
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
      if (k > 50)
        hang();
    end
    while (hreadyout !== 1'b1);
  endtask : rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  // counts falling edges until the line shows the wanted level
  task automatic wf(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v)
    begin
      @(negedge clk);
      c++;
      if (c > 1000)
        hang();
    end
  endtask : wf
  task automatic meas(output int h, output int p);
    int c;
    wf(pin_wire, 1'b0, c);
    wf(pin_wire, 1'b1, c);
    wf(pin_wire, 1'b0, h);
    wf(pin_wire, 1'b1, c);
    p = h + c;
  endtask : meas
  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (ofs[i]) rdc(ofs[i], 32'h0);
    pin_direction_bit <= 1'b0;
    wr(8'h04, 32'h10);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h18, 32'h0);
      wr(8'h14, 32'h1);
      wr(8'h00, {28'h0, mode[i]});
      wf(channel_match_flag, 1'b1, n);
      repeat (3) @(negedge clk);
      chk(pin_wire, lvl[i]);
    end
    port_data_latch <= 1'b1;
    wr(8'h00, 32'h0);
    repeat (3) @(negedge clk);
    chk(pin_wire, 1'b1);
    wr(8'h00, 32'h2);
    repeat (3) @(negedge clk);
    chk(pin_wire, 1'b0);
    wr(8'h18, 32'h0);
    wr(8'h14, 32'h1);
    wr(8'h00, 32'ha);
    wf(channel_match_flag, 1'b1, n);
    repeat (3) @(negedge clk);
    chk(pin_wire, 1'b1);
    wr(8'h1c, 32'h1);
    wr(8'h18, 32'h0);
    wr(8'h14, 32'h1);
    wr(8'h00, 32'hb);
    wf(special_event_trigger, 1'b1, n);
    @(negedge clk);
    wf(special_event_trigger, 1'b1, n);
    chk(n + 1, 17 * TD);
    repeat (2) @(negedge clk);
    chk(conversion_start, 1'b1);
    chk(pin_wire, 1'b1);
    rdc(8'h14, 32'h1);
    bus(1'b0, 8'h18, 32'h0);
    chk(rd[31:5], 27'h0);
    wf(special_event_trigger, 1'b1, n);
    @(posedge clk);
    tick_en <= 1'b0;
    wr(8'h04, 32'h20);
    @(posedge clk);
    tick_en <= 1'b1;
    repeat (20) @(negedge clk);
    bus(1'b0, 8'h18, 32'h0);
    chk(rd[15:4], 12'h001);
    wr(8'h0c, 32'h3);
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h2c);
    wr(8'h10, 32'h4);
    meas(hi, lo);
    meas(hi, lo);
    chk(hi, 6);
    chk(lo, 16);
    wr(8'h08, 32'h55);
    rdc(8'h08, 32'h1);
    wr(8'h04, 32'h2);
    meas(hi, lo);
    meas(hi, lo);
    chk(hi, 10);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'hc);
    repeat (40) @(negedge clk);
    hi = 0;
    repeat (40)
    begin
      @(negedge clk);
      hi += (pin_wire === 1'b1);
    end
    chk(hi, 0);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk);
    chk(channel_output_pin_oe_n, 1'b1);
    chk(channel_output_pin, 1'b0);
    sys_rst <= 1'b0;
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    give_verdict();
  end
endmodule : cpw_top_test
